/* File: pcseq_cfg.svh */
`ifndef PCSEQ_CFG_SVH
`define PCSEQ_CFG_SVH
// ----------------------------------------
// counter layout and fixed vectors
// ----------------------------------------
`define PCSEQ_PC_W        15
`define PCSEQ_ADDR_FLD_W  13
`define PCSEQ_PHASES      4
`define PCSEQ_RESET_VEC   15'h0000
`define PCSEQ_VEC_EXT_A   15'h0004
`define PCSEQ_VEC_EXT_B   15'h0008
`define PCSEQ_VEC_TMR_A   15'h000C
`define PCSEQ_VEC_TMR_B   15'h0010
`define PCSEQ_VEC_UART    15'h0014
`define PCSEQ_VEC_MULTI   15'h0018
`define PCSEQ_BANK_HI_BIT 6
`define PCSEQ_BANK_LO_BIT 5
`define PCSEQ_PAGE_LSB    8
`endif

/* File: pcseq_pkg.sv */
package pcseq_pkg;
   // ----------------------------------------
   // counter load sources
   // ----------------------------------------
   typedef enum logic [3:0] {
      PCSEQ_LD_NONE,
      PCSEQ_LD_IRQ_EXT_A,
      PCSEQ_LD_IRQ_EXT_B,
      PCSEQ_LD_IRQ_TMR_A,
      PCSEQ_LD_IRQ_TMR_B,
      PCSEQ_LD_IRQ_UART,
      PCSEQ_LD_IRQ_MULTI,
      PCSEQ_LD_SKIP,
      PCSEQ_LD_LOW_BYTE,
      PCSEQ_LD_JUMP,
      PCSEQ_LD_RETURN
   } pcseq_load_t;
endpackage

/* File: pcseq_phase_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcseq_cfg.svh"
module pcseq_phase_gen #(
   parameter int PHASES = `PCSEQ_PHASES
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_rst,
   output logic [PHASES-1:0]      o_phase,
   output logic                   o_cycle_end
);
   if (PHASES != 4) begin : g_bad_phases
      $error("phase count must be four");
   end
   logic [PHASES-1:0] ring_r;
   logic [PHASES-1:0] ring_nxt;
   always_comb begin
      ring_nxt = {ring_r[PHASES-2:0], ring_r[PHASES-1]};
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ring_r <= {{(PHASES-1){1'b0}}, 1'b1};
      end else begin
         ring_r <= ring_nxt;
      end
   end
   assign o_phase     = ring_r;
   assign o_cycle_end = ring_r[PHASES-1];
endmodule // pcseq_phase_gen
`default_nettype wire

/* File: pcseq_vec_sel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcseq_cfg.svh"
module pcseq_vec_sel (
   input  wire pcseq_pkg::pcseq_load_t i_src,
   output logic [`PCSEQ_PC_W-1:0]      o_vec
);
   always_comb begin
      case (i_src)
         pcseq_pkg::PCSEQ_LD_IRQ_EXT_A: o_vec = `PCSEQ_VEC_EXT_A;
         pcseq_pkg::PCSEQ_LD_IRQ_EXT_B: o_vec = `PCSEQ_VEC_EXT_B;
         pcseq_pkg::PCSEQ_LD_IRQ_TMR_A: o_vec = `PCSEQ_VEC_TMR_A;
         pcseq_pkg::PCSEQ_LD_IRQ_TMR_B: o_vec = `PCSEQ_VEC_TMR_B;
         pcseq_pkg::PCSEQ_LD_IRQ_UART:  o_vec = `PCSEQ_VEC_UART;
         pcseq_pkg::PCSEQ_LD_IRQ_MULTI: o_vec = `PCSEQ_VEC_MULTI;
         default:                       o_vec = `PCSEQ_RESET_VEC;
      endcase
   end
endmodule // pcseq_vec_sel
`default_nettype wire

/* File: pcseq_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcseq_cfg.svh"
module pcseq_core #(
   parameter int PC_W  = `PCSEQ_PC_W,
   parameter int FLD_W = `PCSEQ_ADDR_FLD_W
) (
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst,
   input  wire logic [15:0]            i_fetch_word,
   input  wire pcseq_pkg::pcseq_load_t i_load_src,
   input  wire logic [FLD_W-1:0]       i_jump_addr,
   input  wire logic [7:0]             i_counter_low_byte,
   input  wire logic [7:0]             i_bank_select_pointer,
   input  wire logic [PC_W-1:0]        i_stack_top,
   output logic [PC_W-1:0]             o_fetch_addr,
   output logic                        o_fetch_strobe,
   output logic [15:0]                 o_exec_word,
   output logic                        o_exec_valid,
   output logic                        o_load_taken,
   output logic [PC_W-1:0]             o_push_value,
   output logic [3:0]                  o_phase,
   output logic [PC_W-1:0]             o_pc
);
   if (PC_W != 15 || FLD_W != 13) begin : g_bad_layout
      $error("counter layout must be 15/13 bits");
   end

   // ----------------------------------------
   // phase generation
   // ----------------------------------------
   logic cycle_end;
   pcseq_phase_gen #(
      .PHASES (4)
   ) u_phase (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .o_phase     (o_phase),
      .o_cycle_end (cycle_end)
   );

   // ----------------------------------------
   // fixed vector lookup
   // ----------------------------------------
   logic [PC_W-1:0] vec;
   pcseq_vec_sel u_vec (
      .i_src (i_load_src),
      .o_vec (vec)
   );

   // ----------------------------------------
   // counter, fetch latch and dummy cycle
   // ----------------------------------------
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] pc_nxt;
   logic [15:0]     exec_word_r;
   logic [15:0]     exec_word_nxt;
   logic            exec_valid_r;
   logic            exec_valid_nxt;
   logic            dummy_r;
   logic            dummy_nxt;
   logic [PC_W-1:0] fetch_addr_r;
   logic [PC_W-1:0] fetch_addr_nxt;
   logic [PC_W-1:0] target;
   logic            load;
   logic [PC_W-1:0] plus_one;
   logic [PC_W-1:0] bank_base;
   logic [FLD_W-1:0] skip_low;

   always_comb begin
      plus_one  = pc_r + 15'h0001;
      bank_base = {pc_r[PC_W-1:FLD_W], {FLD_W{1'b0}}};
      // pc_r points at the discarded word; one more gives plus two
      skip_low  = plus_one[FLD_W-1:0];
      load      = 1'b1;
      case (i_load_src)
         pcseq_pkg::PCSEQ_LD_IRQ_EXT_A,
         pcseq_pkg::PCSEQ_LD_IRQ_EXT_B,
         pcseq_pkg::PCSEQ_LD_IRQ_TMR_A,
         pcseq_pkg::PCSEQ_LD_IRQ_TMR_B,
         pcseq_pkg::PCSEQ_LD_IRQ_UART,
         pcseq_pkg::PCSEQ_LD_IRQ_MULTI: begin
            target = vec;
         end
         pcseq_pkg::PCSEQ_LD_SKIP: begin
            target = bank_base | {2'b00, skip_low};
         end
         pcseq_pkg::PCSEQ_LD_LOW_BYTE: begin
            target = {pc_r[PC_W-1:`PCSEQ_PAGE_LSB], i_counter_low_byte};
         end
         pcseq_pkg::PCSEQ_LD_JUMP: begin
            target = {i_bank_select_pointer[`PCSEQ_BANK_HI_BIT],
                      i_bank_select_pointer[`PCSEQ_BANK_LO_BIT],
                      i_jump_addr};
         end
         pcseq_pkg::PCSEQ_LD_RETURN: begin
            target = i_stack_top;
         end
         default: begin
            target = pc_r;
            load   = 1'b0;
         end
      endcase

      pc_nxt         = pc_r;
      exec_word_nxt  = exec_word_r;
      exec_valid_nxt = exec_valid_r;
      dummy_nxt      = dummy_r;
      fetch_addr_nxt = fetch_addr_r;
      if (cycle_end) begin
         if (load && !dummy_r) begin
            // fetched word is stale: flush it and refetch at target
            pc_nxt         = target;
            fetch_addr_nxt = target;
            exec_valid_nxt = 1'b0;
            dummy_nxt      = 1'b1;
         end else begin
            // execute what was fetched, fetch the next word in parallel
            exec_word_nxt  = i_fetch_word;
            exec_valid_nxt = 1'b1;
            fetch_addr_nxt = plus_one;
            pc_nxt         = plus_one;
            dummy_nxt      = 1'b0;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pc_r         <= `PCSEQ_RESET_VEC;
         fetch_addr_r <= `PCSEQ_RESET_VEC;
         exec_word_r  <= 16'h0000;
         exec_valid_r <= 1'b0;
         dummy_r      <= 1'b0;
      end else begin
         pc_r         <= pc_nxt;
         fetch_addr_r <= fetch_addr_nxt;
         exec_word_r  <= exec_word_nxt;
         exec_valid_r <= exec_valid_nxt;
         dummy_r      <= dummy_nxt;
      end
   end

   assign o_pc           = pc_r;
   assign o_fetch_addr   = fetch_addr_r;
   assign o_fetch_strobe = cycle_end;
   assign o_exec_word    = exec_word_r;
   assign o_exec_valid   = exec_valid_r;
   assign o_load_taken   = cycle_end && load && !dummy_r;
   assign o_push_value   = pc_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_four_phase;
      @(posedge i_core_clk) disable iff (i_rst)
         cycle_end |=> !cycle_end ##1 !cycle_end ##1 !cycle_end ##1 cycle_end;
   endproperty
   a_four_phase: assert property (p_four_phase) else $error("phase period not four");

   property p_incr;
      @(posedge i_core_clk) disable iff (i_rst)
         (cycle_end && !(load && !dummy_r)) |=> pc_r == $past(pc_r) + 15'h0001;
   endproperty
   a_incr: assert property (p_incr) else $error("counter not incremented");

   property p_two_cycle;
      @(posedge i_core_clk) disable iff (i_rst)
         o_load_taken |=> !exec_valid_r ##4 exec_valid_r;
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("dummy cycle missing");

   property p_ext_a;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_IRQ_EXT_A) |=> pc_r == 15'h0004;
   endproperty
   a_ext_a: assert property (p_ext_a) else $error("bad vector a");

   property p_multi;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_IRQ_MULTI) |=> pc_r == 15'h0018;
   endproperty
   a_multi: assert property (p_multi) else $error("bad multi vector");

   property p_jump;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_JUMP) |=>
            pc_r == {$past(i_bank_select_pointer[6]), $past(i_bank_select_pointer[5]),
                     $past(i_jump_addr)};
   endproperty
   a_jump: assert property (p_jump) else $error("bad jump target");

   property p_low_byte;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_LOW_BYTE) |=>
            pc_r[14:8] == $past(pc_r[14:8]) && pc_r[7:0] == $past(i_counter_low_byte);
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("bad page jump");

   property p_ret;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_RETURN) |=> pc_r == $past(i_stack_top);
   endproperty
   a_ret: assert property (p_ret) else $error("bad return target");

   property p_skip;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_SKIP) |=>
            pc_r[14:13] == $past(pc_r[14:13]) && pc_r[12:0] == $past(pc_r[12:0]) + 13'h0001;
   endproperty
   a_skip: assert property (p_skip) else $error("bad skip target");

   // ----------------------------------------
   // checks: remaining vectors and pipeline
   // ----------------------------------------
   property p_ext_b;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_IRQ_EXT_B) |=> pc_r == 15'h0008;
   endproperty
   a_ext_b: assert property (p_ext_b) else $error("bad vector b");

   property p_tmr_a;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_IRQ_TMR_A) |=> pc_r == 15'h000c;
   endproperty
   a_tmr_a: assert property (p_tmr_a) else $error("bad first timer vector");

   property p_tmr_b;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_IRQ_TMR_B) |=> pc_r == 15'h0010;
   endproperty
   a_tmr_b: assert property (p_tmr_b) else $error("bad second timer vector");

   property p_uart;
      @(posedge i_core_clk) disable iff (i_rst)
         (o_load_taken && i_load_src == pcseq_pkg::PCSEQ_LD_IRQ_UART) |=> pc_r == 15'h0014;
   endproperty
   a_uart: assert property (p_uart) else $error("bad uart vector");

   // reset release: counter, fetch address and pipeline start clear
   property p_reset_vec;
      @(posedge i_core_clk) disable iff (i_rst)
         $fell(i_rst) |->
            pc_r == 15'h0000 && fetch_addr_r == 15'h0000 && !exec_valid_r;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset state wrong");

   property p_fetch_exec;
      @(posedge i_core_clk) disable iff (i_rst)
         (cycle_end && !o_load_taken) |=>
            exec_valid_r && exec_word_r == $past(i_fetch_word);
   endproperty
   a_fetch_exec: assert property (p_fetch_exec) else $error("fetched word not executed");

   // counter, fetch address and executed word stand for the whole instruction cycle
   property p_stable;
      @(posedge i_core_clk) disable iff (i_rst)
         !cycle_end |=> pc_r == $past(pc_r) && fetch_addr_r == $past(fetch_addr_r) &&
                        exec_word_r == $past(exec_word_r);
   endproperty
   a_stable: assert property (p_stable) else $error("outputs moved mid cycle");

   property p_onehot;
      @(posedge i_core_clk) disable iff (i_rst)
         $onehot(o_phase);
   endproperty
   a_onehot: assert property (p_onehot) else $error("phase ring not one-hot");

   property p_fetch_follows;
      @(posedge i_core_clk) disable iff (i_rst)
         cycle_end |=> fetch_addr_r == pc_r;
   endproperty
   a_fetch_follows: assert property (p_fetch_follows) else $error("fetch address off");

   property p_dummy_exec;
      @(posedge i_core_clk) disable iff (i_rst)
         (cycle_end && dummy_r) |=> exec_valid_r;
   endproperty
   a_dummy_exec: assert property (p_dummy_exec) else $error("load taken in dummy cycle");

   property p_dummy_len;
      @(posedge i_core_clk) disable iff (i_rst)
         o_load_taken |=> !exec_valid_r [*4];
   endproperty
   a_dummy_len: assert property (p_dummy_len) else $error("dummy cycle too short");

   property p_flush;
      @(posedge i_core_clk) disable iff (i_rst)
         o_load_taken |=> exec_word_r == $past(exec_word_r);
   endproperty
   a_flush: assert property (p_flush) else $error("stale word latched on load");
endmodule // pcseq_core
`default_nettype wire

/* File: pcseq_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// program memory model
// ------------------------------
module pcseq_prog_mem (
   input  wire logic [14:0] i_addr,
   output logic [15:0]      o_word
);
   // every address gives a distinct word, so a wrong fetch address shows
   assign o_word = {i_addr[0], i_addr ^ 15'h2a5c};
endmodule // pcseq_prog_mem
`default_nettype wire

/* File: program_counter_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module program_counter_sequencer_tb_top;
   // ------------------------------
   // signals
   // ------------------------------
   logic                   i_core_clk = 1'b0;
   logic                   i_rst      = 1'b1;
   pcseq_pkg::pcseq_load_t src        = pcseq_pkg::PCSEQ_LD_NONE;
   logic [12:0]            jump_addr  = 13'h0000;
   logic [7:0]             low_byte   = 8'h00;
   logic [7:0]             bank_ptr   = 8'h00;
   logic [14:0]            stack_top  = 15'h0000;
   logic [14:0]            fetch_addr, push_value, pc;
   logic [15:0]            fetch_word, exec_word;
   logic                   fetch_strobe, exec_valid, load_taken;
   logic [3:0]             phase;
   logic [14:0]            exp_pc     = 15'h0000;
   logic                   dummy      = 1'b0;
   logic [32:0]            notes[$];
   int                     fails = 0;
   int                     samples_checked = 0;

   always #25 i_core_clk = ~i_core_clk;

   pcseq_prog_mem pcseq_prog_mem_i (.i_addr(fetch_addr), .o_word(fetch_word));
   pcseq_core pcseq_core_i (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_fetch_word(fetch_word),
      .i_load_src(src), .i_jump_addr(jump_addr), .i_counter_low_byte(low_byte),
      .i_bank_select_pointer(bank_ptr), .i_stack_top(stack_top),
      .o_fetch_addr(fetch_addr), .o_fetch_strobe(fetch_strobe), .o_exec_word(exec_word),
      .o_exec_valid(exec_valid), .o_load_taken(load_taken), .o_push_value(push_value),
      .o_phase(phase), .o_pc(pc));

   // ------------------------------
   // tasks
   // ------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // let the pending request be sampled before its fields change
   task automatic rnd();
      @(posedge i_core_clk);
      #2;
      jump_addr = 13'($urandom);
      low_byte  = 8'($urandom);
      bank_ptr  = 8'($urandom);
      stack_top = 15'($urandom);
   endtask

   // waits for the cycle-end clock, presents a request, notes the outcome
   task automatic cyc(input pcseq_pkg::pcseq_load_t s);
      logic [14:0] tgt;
      logic        take;
      int          n;
      n = 0;
      do begin
         @(posedge i_core_clk);
         #2;
         n++;
      end while (fetch_strobe !== 1'b1 && n < 8);
      if (n >= 8) begin
         fails++;
         wrap_up();
      end
      src  = s;
      take = (s != pcseq_pkg::PCSEQ_LD_NONE) && !dummy;
      case (s)
         pcseq_pkg::PCSEQ_LD_IRQ_EXT_A: tgt = 15'h0004;
         pcseq_pkg::PCSEQ_LD_IRQ_EXT_B: tgt = 15'h0008;
         pcseq_pkg::PCSEQ_LD_IRQ_TMR_A: tgt = 15'h000c;
         pcseq_pkg::PCSEQ_LD_IRQ_TMR_B: tgt = 15'h0010;
         pcseq_pkg::PCSEQ_LD_IRQ_UART:  tgt = 15'h0014;
         pcseq_pkg::PCSEQ_LD_IRQ_MULTI: tgt = 15'h0018;
         pcseq_pkg::PCSEQ_LD_SKIP:      tgt = {exp_pc[14:13], exp_pc[12:0] + 13'h0001};
         pcseq_pkg::PCSEQ_LD_LOW_BYTE:  tgt = {exp_pc[14:8], low_byte};
         pcseq_pkg::PCSEQ_LD_JUMP:      tgt = {bank_ptr[6], bank_ptr[5], jump_addr};
         pcseq_pkg::PCSEQ_LD_RETURN:    tgt = stack_top;
         default:                       tgt = exp_pc;
      endcase
      if (!take)
         tgt = exp_pc + 15'h0001;
      notes.push_back({take, !take, tgt, {exp_pc[0], exp_pc ^ 15'h2a5c}});
      exp_pc = tgt;
      dummy  = take;
   endtask

   // ------------------------------
   // output monitor
   // ------------------------------
   initial begin : monitor
      logic [32:0] nt;
      int          gap;
      gap = 0;
      forever begin
         @(negedge i_core_clk);
         gap++;
         if (i_rst === 1'b1)
            gap = 0;
         if (fetch_strobe === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            check("strobe_gap", 4, gap);
            check("phase", 4'b1000, phase);
            check("load_taken", nt[32], load_taken);
            gap = 0;
            @(posedge i_core_clk);
            #1;
            check("exec_valid", nt[31], exec_valid);
            check("pc", nt[30:16], pc);
            check("push_value", nt[30:16], push_value);
            check("fetch_addr", nt[30:16], fetch_addr);
            if (nt[31])
               check("exec_word", nt[15:0], exec_word);
         end else if (fetch_strobe === 1'b1) begin
            gap = 0;
         end
      end
   end

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin : main
      int s;
      s = $urandom(32'h410a_95f5);
      repeat (12) @(posedge i_core_clk);
      #2;
      i_rst = 1'b0;
      check("pc_reset", 15'h0000, pc);
      check("phase_reset", 4'b0001, phase);
      check("exec_valid_reset", 1'b0, exec_valid);
      repeat (3) cyc(pcseq_pkg::PCSEQ_LD_NONE);
      $display("test sequential done");
      for (s = 1; s <= 10; s++) begin
         rnd();
         cyc(pcseq_pkg::pcseq_load_t'(s));
         cyc(pcseq_pkg::pcseq_load_t'(s));
         repeat (2) cyc(pcseq_pkg::PCSEQ_LD_NONE);
      end
      $display("test every load done");
      jump_addr = 13'h1ffe;
      bank_ptr  = 8'h60;
      cyc(pcseq_pkg::PCSEQ_LD_JUMP);
      cyc(pcseq_pkg::PCSEQ_LD_NONE);
      cyc(pcseq_pkg::PCSEQ_LD_SKIP);
      cyc(pcseq_pkg::PCSEQ_LD_NONE);
      $display("test bank wrap done");
      repeat (60) begin
         rnd();
         cyc(pcseq_pkg::pcseq_load_t'($urandom_range(10, 0)));
      end
      $display("test random mix done");
      repeat (8) @(posedge i_core_clk);
      #2;
      i_rst = 1'b1;
      src   = pcseq_pkg::PCSEQ_LD_NONE;
      #1;
      check("pc_mid_reset", 15'h0000, pc);
      check("fetch_addr_mid_reset", 15'h0000, fetch_addr);
      check("exec_valid_mid_reset", 1'b0, exec_valid);
      repeat (2) @(posedge i_core_clk);
      #2;
      i_rst  = 1'b0;
      exp_pc = 15'h0000;
      dummy  = 1'b0;
      check("phase_mid_reset", 4'b0001, phase);
      repeat (3) cyc(pcseq_pkg::PCSEQ_LD_NONE);
      cyc(pcseq_pkg::PCSEQ_LD_IRQ_TMR_B);
      cyc(pcseq_pkg::PCSEQ_LD_NONE);
      repeat (8) @(posedge i_core_clk);
      $display("test second reset done");
      wrap_up();
   end
endmodule // program_counter_sequencer_tb_top
`default_nettype wire
